/* File: hdl/sst_pkg.sv */
// Shared constants and types for the synchronous serial transmitter
package sst_pkg;

  localparam int unsigned CLK_HZ   = 125000000;
  localparam int unsigned CHAR_W   = 12;
  localparam int unsigned SR_W     = 13;
  localparam int unsigned LEN_W    = 3;
  localparam int unsigned RTS_DLY  = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_HOLD   = 8'h04;
  localparam logic [7:0] OFS_SYNC   = 8'h08;

  // Status register fields
  localparam int unsigned ST_DONE_IE = 0;
  localparam int unsigned ST_IDLE    = 1;
  localparam int unsigned ST_LEN_LO  = 2;
  localparam int unsigned ST_DONE    = 7;
  localparam int unsigned ST_ACTIVE  = 8;
  localparam int unsigned ST_RTS     = 9;
  localparam int unsigned ST_CTS     = 10;
  localparam int unsigned ST_CRDY    = 11;

  // Character length selection codes
  localparam logic [LEN_W-1:0] LEN_6  = 3'h0;
  localparam logic [LEN_W-1:0] LEN_7  = 3'h1;
  localparam logic [LEN_W-1:0] LEN_8  = 3'h2;
  localparam logic [LEN_W-1:0] LEN_10 = 3'h3;
  localparam logic [LEN_W-1:0] LEN_11 = 3'h4;
  localparam logic [LEN_W-1:0] LEN_12 = 3'h5;

  // Values after reset
  localparam logic [CHAR_W-1:0] RST_SYNC = 12'h000;
  localparam logic [LEN_W-1:0]  RST_LEN  = 3'h2;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [7:0]        adr;
    logic [31:0]       dat;
  } sst_wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       dat;
  } sst_wb_rsp_t;

  typedef struct packed {
    logic              rts;
    logic              txd;
  } sst_modem_out_t;

endpackage

/* File: hdl/sst_top.sv */
// Transmit half of a synchronous serial line interface with Wishbone access
//
// Functional notes
// - Buffer write stores character, sets ready-sync flag
// - Ready flag follows sync flag on falling edge
// - Request-to-send rises two clock pulses later
// - No shifting before clear-to-send returns
// - Sync register and length loaded from bus
// - Idle-sync sends sync when character is late
// - Eight-bit marker flop injects trailing one behind buffered characters
// - Seven/six bit modes force marker at load
// - Lengths ten, eleven, twelve also supported
// - Active sets on rising edge after clear-to-send
// - End-of-cycle when upper shift bits all zero
// - End-of-cycle stops shift, next clock loads
// - Load drops end-of-cycle, clears ready-sync flag
// - Ready-sync falling edge sets done flag
// - No new character: ready clears, send drops
// - Ready, idle-sync or no end-of-cycle keeps active and request
// - Idle-sync while no character is ready sends sync repeatedly
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
module sst_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire sst_pkg::sst_wb_req_t  wb_req_i,
  output sst_pkg::sst_wb_rsp_t       wb_rsp_o,
  input  wire logic                  tx_clk_i,
  input  wire logic                  clear_to_send_i,
  output sst_pkg::sst_modem_out_t    modem_o,
  output logic                       done_req_o
);

  typedef struct packed {
    logic [1:0]                    clk_sync;
    logic                          clk_prev;
    logic [1:0]                    cts_sync;
    logic                          ack;
    logic [31:0]                   rdata;
    logic                          done_ie;
    logic                          idle_sync;
    logic [sst_pkg::LEN_W-1:0]     len_sel;
    logic [sst_pkg::CHAR_W-1:0]    sync_reg;
    logic [sst_pkg::CHAR_W-1:0]    hold_buf;
    logic                          char_rdy_sync;
    logic                          char_rdy;
    logic                          eight_bit_marker_ff;
    logic [1:0]                    rts_cnt;
    logic                          rts;
    logic                          active;
    logic [sst_pkg::SR_W-1:0]      shreg;
    logic                          txd;
    logic                          done;
    logic                          done_req;
  } sst_state_t;

  sst_state_t state_ff;
  sst_state_t nxt_state;

  logic                          rise_edge;
  logic                          fall_edge;
  logic                          cts;
  logic                          end_cycle;
  logic                          req_hit;
  logic                          wr_en;
  logic                          hold_load;
  logic                          want_send;
  logic                          do_load;
  logic                          len8;
  logic [3:0]                    len_bits;
  logic [sst_pkg::CHAR_W-1:0]    load_src;
  logic [sst_pkg::SR_W-1:0]      load_vec;
  logic [31:0]                   status_word;
  logic [31:0]                   rd_mux;

  assign rise_edge = state_ff.clk_sync[1] & ~state_ff.clk_prev;
  assign fall_edge = ~state_ff.clk_sync[1] & state_ff.clk_prev;
  assign cts       = state_ff.cts_sync[1];

  // Marker past the last data bit leaves only bits 1 and 0 set
  assign end_cycle = (state_ff.shreg[sst_pkg::SR_W-1:2] == '0);

  assign len8 = (state_ff.len_sel == sst_pkg::LEN_8);

  // Number of data bits for each length selection
  always_comb begin
    case (state_ff.len_sel)
      sst_pkg::LEN_6:  len_bits = 4'h6;
      sst_pkg::LEN_7:  len_bits = 4'h7;
      sst_pkg::LEN_8:  len_bits = 4'h8;
      sst_pkg::LEN_10: len_bits = 4'hA;
      sst_pkg::LEN_11: len_bits = 4'hB;
      sst_pkg::LEN_12: len_bits = 4'hC;
      default:         len_bits = 4'h8;
    endcase
  end

  // Buffer when a character is waiting, otherwise the sync pattern
  assign load_src = state_ff.char_rdy ? state_ff.hold_buf
                                      : state_ff.sync_reg;

  // Bits above the length are suppressed; the bit at the length is the
  // trailing marker. In 8-bit mode the marker comes from its own flop.
  genvar gi;
  generate
    for (gi = 0; gi < sst_pkg::SR_W; gi++) begin : g_load
      if (gi < sst_pkg::CHAR_W) begin : g_dat
        always_comb begin
          if (gi < int'(len_bits)) begin
            load_vec[gi] = load_src[gi];
          end else if (gi == int'(len_bits)) begin
            load_vec[gi] = len8 ? state_ff.eight_bit_marker_ff
                                : 1'b1;
          end else begin
            load_vec[gi] = 1'b0;
          end
        end
      end else begin : g_top
        assign load_vec[gi] = (gi == int'(len_bits));
      end
    end
  endgenerate

  // Bus decode; a write lands at the edge where ack is seen high
  assign req_hit   = wb_req_i.cyc & wb_req_i.stb;
  assign wr_en     = req_hit & wb_req_i.we & state_ff.ack;
  assign hold_load = wr_en & (wb_req_i.adr == sst_pkg::OFS_HOLD) &
                     wb_req_i.sel[0];

  // Send request is held by a waiting character, a character still in
  // flight, or idle-sync fill
  assign want_send = state_ff.char_rdy | state_ff.idle_sync |
                     (state_ff.active & ~end_cycle);

  assign do_load = rise_edge & state_ff.active & cts & end_cycle &
                   (state_ff.char_rdy | state_ff.idle_sync);

  always_comb begin
    status_word                                   = '0;
    status_word[sst_pkg::ST_DONE_IE]              = state_ff.done_ie;
    status_word[sst_pkg::ST_IDLE]                 = state_ff.idle_sync;
    status_word[sst_pkg::ST_LEN_LO +: sst_pkg::LEN_W] = state_ff.len_sel;
    status_word[sst_pkg::ST_DONE]                 = state_ff.done;
    status_word[sst_pkg::ST_ACTIVE]               = state_ff.active;
    status_word[sst_pkg::ST_RTS]                  = state_ff.rts;
    status_word[sst_pkg::ST_CTS]                  = cts;
    status_word[sst_pkg::ST_CRDY]                 = state_ff.char_rdy;
  end

  always_comb begin
    case (wb_req_i.adr)
      sst_pkg::OFS_STATUS: rd_mux = status_word;
      sst_pkg::OFS_HOLD:   rd_mux = {20'h00000, state_ff.hold_buf};
      sst_pkg::OFS_SYNC:   rd_mux = {20'h00000, state_ff.sync_reg};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;

    // Two-flop synchronisers, then an edge detector on the second stage
    nxt_state.clk_sync = {state_ff.clk_sync[0], tx_clk_i};
    nxt_state.clk_prev = state_ff.clk_sync[1];
    nxt_state.cts_sync = {state_ff.cts_sync[0], clear_to_send_i};

    // Single-wait answer; unmapped offsets ack with zero data
    nxt_state.ack   = req_hit & ~state_ff.ack;
    nxt_state.rdata = (req_hit & ~state_ff.ack) ? rd_mux : 32'h00000000;

    if (wr_en && wb_req_i.adr == sst_pkg::OFS_STATUS) begin
      if (wb_req_i.sel[0]) begin
        nxt_state.done_ie   = wb_req_i.dat[sst_pkg::ST_DONE_IE];
        nxt_state.idle_sync = wb_req_i.dat[sst_pkg::ST_IDLE];
        nxt_state.len_sel   =
          wb_req_i.dat[sst_pkg::ST_LEN_LO +: sst_pkg::LEN_W];
      end
    end
    if (wr_en && wb_req_i.adr == sst_pkg::OFS_SYNC) begin
      if (wb_req_i.sel[0]) begin
        nxt_state.sync_reg[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1]) begin
        nxt_state.sync_reg[11:8] = wb_req_i.dat[11:8];
      end
    end
    if (hold_load) begin
      nxt_state.hold_buf[7:0] = wb_req_i.dat[7:0];
      if (wb_req_i.sel[1]) begin
        nxt_state.hold_buf[11:8] = wb_req_i.dat[11:8];
      end
    end

    // Falling edge: ready flag copies the sync flag
    if (fall_edge) begin
      nxt_state.char_rdy = state_ff.char_rdy_sync;
    end

    // Rising edge: request-to-send delay and active flag
    if (rise_edge) begin
      if (!want_send) begin
        nxt_state.rts_cnt = 2'h0;
        nxt_state.rts     = 1'b0;
        nxt_state.active  = 1'b0;
      end else if (state_ff.rts_cnt < 2'(sst_pkg::RTS_DLY)) begin
        nxt_state.rts_cnt = state_ff.rts_cnt + 2'h1;
        nxt_state.rts     = (state_ff.rts_cnt ==
                             2'(sst_pkg::RTS_DLY - 1));
      end
      if (want_send && state_ff.rts && cts) begin
        nxt_state.active = 1'b1;
      end
    end

    // Marker flop arms while a character waits and the shifter has run
    // empty; arming between link edges has it ready before the load
    // edge, also for back-to-back characters
    if (len8 && state_ff.char_rdy && cts && end_cycle) begin
      nxt_state.eight_bit_marker_ff = 1'b1;
    end

    // Shifting waits for both active and clear-to-send
    if (do_load) begin
      nxt_state.shreg               = load_vec;
      nxt_state.txd                 = load_vec[0];
      nxt_state.char_rdy_sync       = 1'b0;
      nxt_state.eight_bit_marker_ff = 1'b0;
    end else if (rise_edge && state_ff.active && cts && !end_cycle) begin
      nxt_state.shreg = state_ff.shreg >> 1;
      nxt_state.txd   = state_ff.shreg[1];
    end

    // A new character beats a simultaneous clear of the sync flag
    if (hold_load) begin
      nxt_state.char_rdy_sync = 1'b1;
    end

    // Done sets on the sync flag's fall and clears on a buffer write;
    // a write in the load cycle keeps the flag up, so the clear wins
    if (hold_load) begin
      nxt_state.done = 1'b0;
    end
    if (state_ff.char_rdy_sync && !nxt_state.char_rdy_sync) begin
      nxt_state.done = 1'b1;
    end
    nxt_state.done_req = nxt_state.done & nxt_state.done_ie;

    // Idle state after reset
    if (rst_i) begin
      nxt_state                     = '0;
      nxt_state.len_sel             = sst_pkg::RST_LEN;
      nxt_state.sync_reg            = sst_pkg::RST_SYNC;
    end
  end

  always_ff @(posedge clk_i) begin
    state_ff <= nxt_state;
  end

  assign wb_rsp_o.ack  = state_ff.ack;
  assign wb_rsp_o.dat  = state_ff.rdata;
  assign modem_o.rts   = state_ff.rts;
  assign modem_o.txd   = state_ff.txd;
  assign done_req_o    = state_ff.done_req;

endmodule

/* File: testbench/sst_modem_model.sv */
// Modem side: transmit clock and clear-to-send answer
`timescale 1ns/1ns
module sst_modem_model (
  input  wire logic rts_i,
  input  wire logic slow_i,
  output logic      tx_clk_o,
  output logic      cts_o
);
  int unsigned cnt;
  initial begin
    tx_clk_o = 1'b0;
    cts_o = 1'b0;
    cnt = 0;
  end
  // Synchronous modem timing runs free, also outside frames
  always begin
    #62 tx_clk_o = 1'b1;
    #63 tx_clk_o = 1'b0;
  end
  // Answer at the second or fifth rising edge with the request; drop at the next rising edge without it
  always @(posedge tx_clk_o) begin
    if (!rts_i) begin
      cts_o <= 1'b0;
      cnt <= 0;
    end else if (cnt >= (slow_i ? 4 : 1)) cts_o <= 1'b1;
    else cnt <= cnt + 1;
  end
endmodule

/* File: testbench/sst_top_properties.sv */
// Port-level checks of the serial transmitter
`timescale 1ns/1ns
module sst_top_checker (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire sst_pkg::sst_wb_req_t    wb_req_i,
  input wire sst_pkg::sst_wb_rsp_t    wb_rsp_o,
  input wire logic                    tx_clk_i,
  input wire logic                    clear_to_send_i,
  input wire sst_pkg::sst_modem_out_t modem_o,
  input wire logic                    done_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_next;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_dat_zero; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("read data");
  property p_rst;
    disable iff (1'b0) rst_i |=> !modem_o.rts && !done_req_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_txd_edge; $changed(modem_o.txd) |-> tx_clk_i; endproperty
  a_txd_edge: assert property (p_txd_edge) else $error("txd edge");
  property p_rts_edge; $changed(modem_o.rts) |-> tx_clk_i; endproperty
  a_rts_edge: assert property (p_rts_edge) else $error("rts edge");
  // Six cycles covers the two-flop sync plus edge detection
  property p_txd_cts;
    !clear_to_send_i [*6] |=> $stable(modem_o.txd);
  endproperty
  a_txd_cts: assert property (p_txd_cts) else $error("shift w/o cts");
  property p_txd_rts; $changed(modem_o.txd) |-> $past(modem_o.rts); endproperty
  a_txd_rts: assert property (p_txd_rts) else $error("txd w/o rts");
endmodule
bind sst_top sst_top_checker sst_top_checker_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .tx_clk_i(tx_clk_i), .clear_to_send_i(clear_to_send_i),
  .modem_o(modem_o), .done_req_o(done_req_o));

/* File: testbench/sst_top_tb.sv */
// Self-checking bench for the serial transmitter
`timescale 1ns/1ns
module sst_top_tb;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    slow = 1'b0;
  logic                    tx_clk, cts, done_req;
  sst_pkg::sst_wb_req_t    req = '0;
  sst_pkg::sst_wb_rsp_t    rsp;
  sst_pkg::sst_modem_out_t modem;
  logic [31:0]             q;
  logic [11:0]             ch [3];
  int                      miscompares = 0;
  int                      checked = 0;
  int                      w, len;
  int                      width [6] = '{6, 7, 8, 10, 11, 12};
  logic                    cap [$];
  logic                    exp_q [$];
  always #4 clk_i = ~clk_i;
  sst_top sst_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .tx_clk_i(tx_clk), .clear_to_send_i(cts),
    .modem_o(modem), .done_req_o(done_req));
  sst_modem_model sst_modem_model_inst (.rts_i(modem.rts), .slow_i(slow),
    .tx_clk_o(tx_clk), .cts_o(cts));
  // Mid-cell sampling keeps clear of the shifter's update
  always @(negedge tx_clk) if (modem.rts === 1'b1 && cts === 1'b1)
    cap.push_back(modem.txd);
  task test_done;
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, 4'hF, a, d};
    // Request stands until the edge that samples ack; data taken there
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask
  task wait_rts(input logic v);
    for (w = 0; w < 30000 && modem.rts !== v; w++) @(posedge clk_i);
    chk(modem.rts, v, "rts");
  endtask
  task push(input logic [11:0] c, input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(c[i]);
  endtask
  // Bits ahead of the first load are idle fill, so only the tail counts
  task cmp_tail;
    for (int i = 0; i < exp_q.size(); i++)
      chk(cap[cap.size() - exp_q.size() + i], exp_q[i], "line bit");
  endtask
  initial begin
    #600000;
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(8213));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, sst_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'h0000_0008, "status");
    wb(1'b0, sst_pkg::OFS_SYNC, 32'h0);
    chk(q, 32'h0, "sync");
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0, "unmapped");
    for (len = 0; len < 6; len++) begin
      slow <= len[0];
      ch[0] = 12'($urandom);
      ch[1] = ch[0];
      ch[2] = 12'($urandom);
      wb(1'b1, sst_pkg::OFS_SYNC, 32'(ch[0]));
      wb(1'b1, sst_pkg::OFS_STATUS, 32'(len * 4 + 1));
      cap.delete();
      exp_q.delete();
      for (int k = 0; k < 3; k++) begin
        wb(1'b1, sst_pkg::OFS_HOLD, 32'(ch[k]));
        push(ch[k], width[len]);
        repeat (3) @(posedge clk_i);
        for (w = 0; w < 30000 && done_req !== 1'b1; w++) @(posedge clk_i);
        chk(done_req, 1'b1, "done");
      end
      wait_rts(1'b0);
      cmp_tail;
    end
    ch[0] = 12'($urandom);
    wb(1'b1, sst_pkg::OFS_SYNC, 32'(ch[0]));
    wb(1'b1, sst_pkg::OFS_STATUS, 32'h0000_0002);
    cap.delete();
    exp_q.delete();
    wait_rts(1'b1);
    repeat (600) @(posedge clk_i);
    wb(1'b1, sst_pkg::OFS_STATUS, 32'h0);
    wait_rts(1'b0);
    push(ch[0], 6);
    push(ch[0], 6);
    cmp_tail;
    wb(1'b1, sst_pkg::OFS_STATUS, 32'h0000_0009);
    wb(1'b1, sst_pkg::OFS_HOLD, 32'($urandom));
    wait_rts(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(modem.rts, 1'b0, "rts after reset");
    chk(done_req, 1'b0, "done after reset");
    test_done;
  end
endmodule
